// ==== test/tes_ctrl_bench.sv ====
// self-checking bench of the trigger controller
`timescale 1ns/1ps
`include "tes_map.svh"
module tes_ctrl_bench;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [2:0]  go      = 3'b000;
    logic [15:0] wid     = 16'h0000;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_out_one, ext_out_two, exposure_active, readout_active;
    logic [2:0]  trig;
    logic [31:0] r;
    logic        e;
    wire  [3:0]  obs = {ext_out_two, ext_out_one, readout_active, exposure_active};
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc       = 0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    tes_ctrl #(.TICK_CYC(2)) u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_input_one(trig[0]),
        .external_input_two(trig[1]), .pulse_gen_in(trig[2]), .ext_out_one(ext_out_one),
        .ext_out_two(ext_out_two), .exposure_active(exposure_active),
        .readout_active(readout_active));
    for (genvar i = 0; i < 3; i++) begin : g_src
        tes_trig_src u_src (.sys_clk(sys_clk), .go(go[i]), .idle_lvl(i == 1), .width(wid),
            .line(trig[i]));
    end
    task end_of_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task rng(input string n, input int lo, input int hi, input int v);
        tests_run++;
        if (v < lo || v > hi) begin
            err_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", n, lo, hi, v);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask
    task wt(input int s, input logic l, output int n);
        n = 0;
        #1;
        while (obs[s] !== l && n < 6000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 6000) begin
            err_count++;
            $display("mismatch wait %0d expected %b seen timeout", s, l);
        end
    endtask
    task idle;
        int n;
        wt(0, 1'b0, n);
        repeat (2) @(posedge sys_clk);
        wt(1, 1'b0, n);
    endtask
    task fire(input int i, input logic [15:0] w);
        @(posedge sys_clk);
        go[i] <= 1'b1;
        wid <= w;
        @(posedge sys_clk);
        go[i] <= 1'b0;
    endtask
    task t_reset;
        int n;
        wt(0, 1'b1, n); rng("free-run start", 0, 2, n);
        apb(1'b0, 8'h30, 32'h0, r, e); chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        apb(1'b0, `TES_A_EXP, 32'h0, r, e); chk("exposure reset", 32'h3E8, r);
        wr(`TES_A_EXP, 32'h14); wr(`TES_A_RO, 32'h14);
        wr(`TES_A_S0DLY, 32'h2); wr(`TES_A_S0WID, 32'h3);
        wr(`TES_A_S1DLY, 32'h0); wr(`TES_A_S1WID, 32'h2); wr(`TES_A_STBCFG, 32'hA);
        wr(`TES_A_CTRL, 32'h7);
        idle;
        apb(1'b0, `TES_A_CMD, 32'h0, r, e); chk("command read", 32'h0, r);
    endtask
    task t_soft;
        int n, k;
        wr(`TES_A_CMD, 32'h1);
        wt(0, 1'b1, n); rng("soft start", 0, 3, n);
        k = cyc;
        wt(2, 1'b1, n); rng("strobe0 delay", 3, 7, n);
        wt(2, 1'b0, n); rng("strobe0 width", 4, 8, n);
        wt(0, 1'b0, n); rng("exposure length", 37, 41, cyc - k);
        wt(1, 1'b1, n); rng("readout start", 0, 1, n);
        k = cyc;
        wt(3, 1'b1, n); rng("strobe1 delay", 0, 4, n);
        wt(3, 1'b0, n); rng("strobe1 width", 2, 6, n);
        wt(1, 1'b0, n); rng("readout length", 37, 41, cyc - k);
        idle;
    endtask
    task t_delay;
        int n, k;
        wr(`TES_A_DLY, 32'hA);
        k = cyc;
        wr(`TES_A_CMD, 32'h1);
        wt(0, 1'b1, n); rng("delayed start", 21, 29, cyc - k);
        wr(`TES_A_CMD, 32'h1);
        wt(0, 1'b0, n);
        wr(`TES_A_CMD, 32'h1);
        idle;
        apb(1'b0, `TES_A_STATUS, 32'h0, r, e); chk("dropped count", 32'h2, r[15:8]);
        wr(`TES_A_DLY, 32'h0);
    endtask
    task t_ext;
        int n, k;
        wr(`TES_A_INCFG, 32'h103); wr(`TES_A_CTRL, 32'h9);
        k = cyc;
        fire(0, 16'd200);
        wt(0, 1'b1, n); rng("debounced start", 24, 33, cyc - k);
        k = cyc;
        wt(0, 1'b0, n); rng("pulse exposure", 190, 212, cyc - k);
        idle;
        fire(0, 16'd60);
        wt(0, 1'b1, n);
        k = cyc;
        wt(0, 1'b0, n); rng("minimum exposure", 98, 110, cyc - k);
        idle;
        wr(`TES_A_CTRL, 32'hB);
        fire(1, 16'd100);
        wt(0, 1'b1, n);
        k = cyc;
        wt(0, 1'b0, n); rng("falling exposure", 95, 106, cyc - k);
        fire(1, 16'd100);
        wt(0, 1'b1, n); chk("overlap", 32'h1, {31'h0, readout_active});
        idle;
        wr(`TES_A_CTRL, 32'h5);
        fire(2, 16'd4);
        wt(0, 1'b1, n); rng("pulse gen start", 0, 8, n);
        idle;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_soft;
        t_delay;
        t_ext;
        end_of_test;
    end
    initial begin
        #800000;
        err_count++;
        $display("mismatch watchdog expected done seen timeout");
        end_of_test;
    end
endmodule

// ==== test/tes_ctrl_properties.sv ====
// port checks of the trigger controller
`timescale 1ns/1ps
module tes_ctrl_properties (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        external_input_one,
    input wire logic        external_input_two,
    input wire logic        pulse_gen_in,
    input wire logic        ext_out_one,
    input wire logic        ext_out_two,
    input wire logic        exposure_active,
    input wire logic        readout_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ready_high_a: assert property (psel |-> pready) else $error("pready low");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h2C && paddr[1:0] == 2'b00
        |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    mapped_ok_a: assert property (psel && penable && paddr <= 8'h2C && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped access refused");
    cmd_reads_zero_a: assert property (
        psel && penable && !pwrite && paddr == 8'h08 |-> prdata == 32'h0)
        else $error("command register read not zero");
    reset_quiet_a: assert property ($fell(rst) |->
        !readout_active && !ext_out_one && !ext_out_two) else $error("outputs busy after reset");
    free_run_a: assert property ($fell(rst) |-> ##[1:2] exposure_active)
        else $error("no free-run exposure after reset");
    exp_then_ro_a: assert property ($fell(exposure_active) |-> ##[0:1] readout_active)
        else $error("no readout after exposure");
    exp_hold_a: assert property ($rose(exposure_active) |=> exposure_active [*2])
        else $error("exposure too short");
    ro_hold_a: assert property ($rose(readout_active) |=> readout_active [*2])
        else $error("readout too short");
endmodule
bind tes_ctrl tes_ctrl_properties u_props (.*);

// ==== test/tes_trig_src.sv ====
// trigger source model driving one external line
`timescale 1ns/1ps
module tes_trig_src (
    input  wire logic        sys_clk,
    input  wire logic        go,
    input  wire logic        idle_lvl,
    input  wire logic [15:0] width,
    output logic             line
);
    logic [15:0] left_r = 16'h0000;
    // pulses are always longer than the chosen de-bounce interval
    always @(posedge sys_clk) begin
        if (go) begin
            left_r <= width;
        end else if (left_r != 16'h0000) begin
            left_r <= left_r - 16'h0001;
        end
    end
    assign line = (left_r != 16'h0000) ? !idle_lvl : idle_lvl;
endmodule

// ==== verilog/tes_ctrl.sv ====
// trigger source, exposure sequencer, readout timer and strobe control with APB registers
// How it works
// - one trigger source is selected from input one, input two, the pulse generator or software.
// - with triggering disabled, exposures and readouts follow one another without a trigger.
// - a software command gives one single-cycle trigger and always uses the exposure register.
// - each trigger input fires on its chosen edge, rising or falling.
// - each external input has a de-bounce interval of off, 10, 50, 100, 500 us, 1, 5 or 10 ms.
// - exposure length comes from the pulse width or the exposure register, never both.
// - in trigger mode the block idles, exposes on a trigger, reads out, then idles again.
// - with pulse-width exposure a trigger during readout starts the next exposure at once, overlapping that readout.
// - with timer exposure the exposure starts after the programmed trigger delay.
// - the trigger delay spans zero to one second in one microsecond steps.
// - with timer exposure a trigger before exposure and readout both end is discarded.
// - two strobes each have a width and a delay from exposure start or readout start.
// - strobe width and delay reach one second in microsecond steps; each goes to either output.
// - pulse-width exposure lasts while the trigger stays at its active level.
// - pulse-width exposure lasts at least fifty microseconds.
`timescale 1ns/1ps
`include "tes_map.svh"
module tes_ctrl #(
    parameter int TICK_CYC = `TES_US_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        external_input_one,
    input  wire logic        external_input_two,
    input  wire logic        pulse_gen_in,
    output logic             ext_out_one,
    output logic             ext_out_two,
    output logic             exposure_active,
    output logic             readout_active
);
    import tes_pkg::*;

    logic          trig_en_r;
    tes_src_e      src_r;
    logic          pw_sel_r;
    logic [8:0]    incfg_r;
    logic          sw_pulse_r;
    tes_us_t       exp_us_r;
    tes_us_t       dly_us_r;
    tes_us_t       ro_us_r;
    tes_us_t       sdly_r [2];
    tes_us_t       swid_r [2];
    logic [3:0]    stbcfg_r;
    logic [7:0]    drop_cnt_r;
    logic [31:0]   prdata_r;
    logic          pslverr_r;
    logic [15:0]   div_r;
    logic          tick;
    logic          pg_lvl_r;
    logic          pg_hit;
    logic          trig_hit;
    logic          trig_act;
    logic          pw_eff;
    logic          accept;
    tes_exp_st_e   st_r;
    tes_exp_st_e   st_nxt;
    tes_us_t       cnt_r;
    logic          ro_busy_r;
    tes_us_t       ro_cnt_r;
    logic          ro_start;
    logic          exp_start;
    logic          exp_act_r;
    logic          out1_r;
    logic          out2_r;
    logic          wr;
    logic          rd_setup;
    logic [1:0]    stb_pulse;

    tes_cond_if cin1 ();
    tes_cond_if cin2 ();

    function automatic tes_us_t clamp_us(input logic [31:0] d);
        if (d > {12'h000, `TES_MAX_US}) begin
            return `TES_MAX_US;
        end
        return d[19:0];
    endfunction

    // microsecond tick shared by every timer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_r <= 16'h0000;
        end else if (clk_en) begin
            if (tick) begin
                div_r <= 16'h0000;
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end
    assign tick = (div_r >= 16'(TICK_CYC - 1));

    // external trigger conditioning
    assign cin1.raw      = external_input_one;
    assign cin1.rise_sel = incfg_r[`TES_IN1_RISE];
    assign cin1.db_sel   = incfg_r[`TES_IN1_DB];
    assign cin1.tick     = tick;
    assign cin2.raw      = external_input_two;
    assign cin2.rise_sel = incfg_r[`TES_IN2_RISE];
    assign cin2.db_sel   = incfg_r[`TES_IN2_DB];
    assign cin2.tick     = tick;

    tes_trig_cond u_cond_one (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .io      (cin1)
    );

    tes_trig_cond u_cond_two (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .io      (cin2)
    );

    // pulse generator runs on this clock, so only an edge detector
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pg_lvl_r <= 1'b0;
        end else if (clk_en) begin
            pg_lvl_r <= pulse_gen_in;
        end
    end
    assign pg_hit = (pulse_gen_in != pg_lvl_r) && (pulse_gen_in == incfg_r[`TES_PG_RISE]);

    // trigger source select
    always_comb begin
        case (src_r)
            TES_SRC_IN1: begin
                trig_hit = cin1.hit;
                trig_act = cin1.act;
            end
            TES_SRC_IN2: begin
                trig_hit = cin2.hit;
                trig_act = cin2.act;
            end
            TES_SRC_PGEN: begin
                trig_hit = pg_hit;
                trig_act = (pulse_gen_in == incfg_r[`TES_PG_RISE]);
            end
            default: begin
                trig_hit = sw_pulse_r;
                trig_act = 1'b0;
            end
        endcase
    end

    // software source never uses pulse width; free-run always uses the timer
    assign pw_eff = trig_en_r && pw_sel_r && (src_r != TES_SRC_SW);

    always_comb begin
        if (!trig_en_r) begin
            accept = (st_r == TES_EX_IDLE);
        end else if (pw_eff) begin
            accept = trig_hit && (st_r == TES_EX_IDLE);
        end else begin
            accept = trig_hit && (st_r == TES_EX_IDLE) && !ro_busy_r;
        end
    end

    // exposure sequencer
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            TES_EX_IDLE: begin
                if (accept) begin
                    if (pw_eff || !trig_en_r || dly_us_r == 20'h00000) begin
                        st_nxt = TES_EX_EXPOSE;
                    end else begin
                        st_nxt = TES_EX_DELAY;
                    end
                end
            end
            TES_EX_DELAY: begin
                if (cnt_r >= dly_us_r) begin
                    st_nxt = TES_EX_EXPOSE;
                end
            end
            TES_EX_EXPOSE: begin
                if (pw_eff ? (!trig_act && cnt_r >= `TES_MIN_EXP_US)
                           : (cnt_r >= exp_us_r)) begin
                    st_nxt = ro_busy_r ? TES_EX_HOLD : TES_EX_IDLE;
                end
            end
            TES_EX_HOLD: begin
                if (!ro_busy_r) begin
                    st_nxt = TES_EX_IDLE;
                end
            end
            default: st_nxt = TES_EX_IDLE;
        endcase
    end

    assign exp_start = (st_nxt == TES_EX_EXPOSE) && (st_r != TES_EX_EXPOSE);
    assign ro_start  = ((st_r == TES_EX_EXPOSE) || (st_r == TES_EX_HOLD))
                     && (st_nxt == TES_EX_IDLE);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r      <= TES_EX_IDLE;
            cnt_r     <= 20'h00000;
            exp_act_r <= 1'b0;
        end else if (clk_en) begin
            st_r      <= st_nxt;
            exp_act_r <= (st_nxt == TES_EX_EXPOSE);
            if (st_nxt != st_r) begin
                cnt_r <= 20'h00000;
            end else if (tick && cnt_r != `TES_MAX_US) begin
                cnt_r <= cnt_r + 20'h00001;
            end
        end
    end

    // readout timer; a new exposure may run beside it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ro_busy_r <= 1'b0;
            ro_cnt_r  <= 20'h00000;
        end else if (clk_en) begin
            if (ro_start) begin
                ro_busy_r <= 1'b1;
                ro_cnt_r  <= 20'h00000;
            end else if (ro_busy_r) begin
                if (ro_cnt_r >= ro_us_r) begin
                    ro_busy_r <= 1'b0;
                end else if (tick) begin
                    ro_cnt_r <= ro_cnt_r + 20'h00001;
                end
            end
        end
    end

    // triggers thrown away by the sequencer are counted
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            drop_cnt_r <= 8'h00;
        end else if (clk_en) begin
            if (trig_en_r && trig_hit && !accept && drop_cnt_r != 8'hFF) begin
                drop_cnt_r <= drop_cnt_r + 8'h01;
            end
        end
    end

    // strobes
    for (genvar g = 0; g < 2; g++) begin : g_stb
        tes_stb_if sif ();
        assign sif.tick  = tick;
        assign sif.start = stbcfg_r[g] ? ro_start : exp_start;
        assign sif.dly   = sdly_r[g];
        assign sif.wid   = swid_r[g];
        assign stb_pulse[g] = sif.pulse;
        tes_strobe u_stb (
            .sys_clk (sys_clk),
            .rst     (rst),
            .clk_en  (clk_en),
            .io      (sif)
        );
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            out1_r <= 1'b0;
            out2_r <= 1'b0;
        end else if (clk_en) begin
            out1_r <= stb_pulse[stbcfg_r[`TES_SC_OUT1]];
            out2_r <= stb_pulse[stbcfg_r[`TES_SC_OUT2]];
        end
    end

    // APB register access
    assign wr       = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            trig_en_r  <= 1'b0;
            src_r      <= TES_SRC_IN1;
            pw_sel_r   <= 1'b0;
            incfg_r    <= 9'h000;
            exp_us_r   <= `TES_EXP_RST;
            dly_us_r   <= 20'h00000;
            ro_us_r    <= `TES_RO_RST;
            sdly_r[0]  <= 20'h00000;
            sdly_r[1]  <= 20'h00000;
            swid_r[0]  <= 20'h00000;
            swid_r[1]  <= 20'h00000;
            stbcfg_r   <= 4'h0;
            sw_pulse_r <= 1'b0;
        end else if (clk_en) begin
            sw_pulse_r <= 1'b0;
            if (wr) begin
                case (paddr)
                    `TES_A_CTRL: begin
                        trig_en_r <= pwdata[`TES_CTRL_EN];
                        src_r     <= tes_src_e'(pwdata[`TES_CTRL_SRC]);
                        pw_sel_r  <= pwdata[`TES_CTRL_PW];
                    end
                    `TES_A_INCFG:  incfg_r    <= pwdata[8:0];
                    `TES_A_CMD:    sw_pulse_r <= pwdata[`TES_CMD_SW];
                    `TES_A_EXP:    exp_us_r   <= clamp_us(pwdata);
                    `TES_A_DLY:    dly_us_r   <= clamp_us(pwdata);
                    `TES_A_RO:     ro_us_r    <= clamp_us(pwdata);
                    `TES_A_S0DLY:  sdly_r[0]  <= clamp_us(pwdata);
                    `TES_A_S0WID:  swid_r[0]  <= clamp_us(pwdata);
                    `TES_A_S1DLY:  sdly_r[1]  <= clamp_us(pwdata);
                    `TES_A_S1WID:  swid_r[1]  <= clamp_us(pwdata);
                    `TES_A_STBCFG: stbcfg_r   <= pwdata[3:0];
                    default:       sw_pulse_r <= 1'b0;
                endcase
            end
        end
    end

    // read data and error are prepared in the setup cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            if (rd_setup) begin
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h00000000;
                case (paddr)
                    `TES_A_CTRL:   prdata_r <= {28'h0000000, pw_sel_r, src_r, trig_en_r};
                    `TES_A_INCFG:  prdata_r <= {23'h000000, incfg_r};
                    `TES_A_CMD:    prdata_r <= 32'h00000000;
                    `TES_A_EXP:    prdata_r <= {12'h000, exp_us_r};
                    `TES_A_DLY:    prdata_r <= {12'h000, dly_us_r};
                    `TES_A_RO:     prdata_r <= {12'h000, ro_us_r};
                    `TES_A_S0DLY:  prdata_r <= {12'h000, sdly_r[0]};
                    `TES_A_S0WID:  prdata_r <= {12'h000, swid_r[0]};
                    `TES_A_S1DLY:  prdata_r <= {12'h000, sdly_r[1]};
                    `TES_A_S1WID:  prdata_r <= {12'h000, swid_r[1]};
                    `TES_A_STBCFG: prdata_r <= {28'h0000000, stbcfg_r};
                    `TES_A_STATUS: prdata_r <= {16'h0000, drop_cnt_r, 2'h0, stb_pulse,
                                                cin2.lvl, cin1.lvl, ro_busy_r, exp_act_r};
                    default:       pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    assign prdata          = prdata_r;
    assign pslverr         = pslverr_r;
    assign pready          = 1'b1;
    assign exposure_active = exp_act_r;
    assign readout_active  = ro_busy_r;
    assign ext_out_one     = out1_r;
    assign ext_out_two     = out2_r;
endmodule

// ==== verilog/tes_if.sv ====
// interfaces between the controller and its input conditioner and strobe generators
`timescale 1ns/1ps
interface tes_cond_if;
    import tes_pkg::*;
    logic    raw;
    logic    rise_sel;
    tes_db_t db_sel;
    logic    tick;
    logic    lvl;
    logic    act;
    logic    hit;
    modport cond (input raw, rise_sel, db_sel, tick, output lvl, act, hit);
    modport ctrl (output raw, rise_sel, db_sel, tick, input lvl, act, hit);
endinterface

interface tes_stb_if;
    import tes_pkg::*;
    logic    tick;
    logic    start;
    tes_us_t dly;
    tes_us_t wid;
    logic    pulse;
    modport gen  (input tick, start, dly, wid, output pulse);
    modport ctrl (output tick, start, dly, wid, input pulse);
endinterface

// ==== verilog/tes_map.svh ====
// register map, field positions, reset values and timing constants of the trigger controller
`ifndef TES_MAP_SVH
`define TES_MAP_SVH
`define TES_CLK_NS      40
`define TES_US_NS       1000
`define TES_US_CYC      ((`TES_US_NS + `TES_CLK_NS - 1) / `TES_CLK_NS)
`define TES_MAX_US      20'hF4240
`define TES_MIN_EXP_US  20'h00032
`define TES_DB_10US     20'h0000A
`define TES_DB_50US     20'h00032
`define TES_DB_100US    20'h00064
`define TES_DB_500US    20'h001F4
`define TES_DB_1MS      20'h003E8
`define TES_DB_5MS      20'h01388
`define TES_DB_10MS     20'h02710
`define TES_A_CTRL      8'h00
`define TES_A_INCFG     8'h04
`define TES_A_CMD       8'h08
`define TES_A_EXP       8'h0C
`define TES_A_DLY       8'h10
`define TES_A_RO        8'h14
`define TES_A_S0DLY     8'h18
`define TES_A_S0WID     8'h1C
`define TES_A_S1DLY     8'h20
`define TES_A_S1WID     8'h24
`define TES_A_STBCFG    8'h28
`define TES_A_STATUS    8'h2C
`define TES_CTRL_EN     0
`define TES_CTRL_SRC    2:1
`define TES_CTRL_PW     3
`define TES_IN1_RISE    0
`define TES_IN1_DB      3:1
`define TES_IN2_RISE    4
`define TES_IN2_DB      7:5
`define TES_PG_RISE     8
`define TES_CMD_SW      0
`define TES_SC_REF0     0
`define TES_SC_REF1     1
`define TES_SC_OUT1     2
`define TES_SC_OUT2     3
`define TES_EXP_RST     20'h003E8
`define TES_RO_RST      20'h003E8
`endif

// ==== verilog/tes_pkg.sv ====
// types shared by the trigger, exposure and strobe controller
package tes_pkg;
    typedef enum logic [1:0] {TES_SRC_IN1, TES_SRC_IN2, TES_SRC_PGEN, TES_SRC_SW} tes_src_e;
    typedef enum {TES_EX_IDLE, TES_EX_DELAY, TES_EX_EXPOSE, TES_EX_HOLD} tes_exp_st_e;
    typedef enum {TES_SB_IDLE, TES_SB_WAIT, TES_SB_ON} tes_stb_st_e;
    typedef logic [19:0] tes_us_t;
    typedef logic [2:0]  tes_db_t;
endpackage

// ==== verilog/tes_strobe.sv ====
// one strobe pulse generator with microsecond delay and width
`timescale 1ns/1ps
module tes_strobe (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    tes_stb_if.gen   io
);
    import tes_pkg::*;
    tes_stb_st_e st_r;
    tes_us_t     cnt_r;

    // a new reference event restarts the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r  <= TES_SB_IDLE;
            cnt_r <= 20'h00000;
        end else if (clk_en) begin
            if (io.start) begin
                cnt_r <= 20'h00000;
                if (io.wid == 20'h00000) begin
                    st_r <= TES_SB_IDLE;
                end else if (io.dly == 20'h00000) begin
                    st_r <= TES_SB_ON;
                end else begin
                    st_r <= TES_SB_WAIT;
                end
            end else begin
                case (st_r)
                    TES_SB_WAIT: begin
                        if (cnt_r >= io.dly) begin
                            st_r  <= TES_SB_ON;
                            cnt_r <= 20'h00000;
                        end else if (io.tick) begin
                            cnt_r <= cnt_r + 20'h00001;
                        end
                    end
                    TES_SB_ON: begin
                        if (cnt_r >= io.wid) begin
                            st_r  <= TES_SB_IDLE;
                            cnt_r <= 20'h00000;
                        end else if (io.tick) begin
                            cnt_r <= cnt_r + 20'h00001;
                        end
                    end
                    default: st_r <= TES_SB_IDLE;
                endcase
            end
        end
    end

    assign io.pulse = (st_r == TES_SB_ON);
endmodule

// ==== verilog/tes_trig_cond.sv ====
// synchroniser, de-bounce filter and edge detector for one external trigger line
`timescale 1ns/1ps
module tes_trig_cond (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    tes_cond_if.cond io
);
    import tes_pkg::*;
    logic    sync_a_r;
    logic    sync_b_r;
    logic    lvl_r;
    logic    hit_r;
    tes_us_t cnt_r;
    tes_us_t lim;

    always_comb begin
        case (io.db_sel)
            3'h1:    lim = `TES_DB_10US;
            3'h2:    lim = `TES_DB_50US;
            3'h3:    lim = `TES_DB_100US;
            3'h4:    lim = `TES_DB_500US;
            3'h5:    lim = `TES_DB_1MS;
            3'h6:    lim = `TES_DB_5MS;
            3'h7:    lim = `TES_DB_10MS;
            default: lim = 20'h00000;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_a_r <= 1'b0;
            sync_b_r <= 1'b0;
        end else if (clk_en) begin
            sync_a_r <= io.raw;
            sync_b_r <= sync_a_r;
        end
    end

    // new level taken only after it held for the whole interval; off passes at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lvl_r <= 1'b0;
            cnt_r <= 20'h00000;
            hit_r <= 1'b0;
        end else if (clk_en) begin
            hit_r <= 1'b0;
            if (sync_b_r == lvl_r) begin
                cnt_r <= 20'h00000;
            end else if (lim == 20'h00000 || cnt_r >= lim) begin
                lvl_r <= sync_b_r;
                cnt_r <= 20'h00000;
                hit_r <= (sync_b_r == io.rise_sel);
            end else if (io.tick) begin
                cnt_r <= cnt_r + 20'h00001;
            end
        end
    end

    assign io.lvl = lvl_r;
    assign io.act = (lvl_r == io.rise_sel);
    assign io.hit = hit_r;
endmodule
